// ===== hdl/sss_pkg.sv
// Function
// - each output may assert from any detector, input, watchdog, manual reset, margin
// - per-output deassert delay picked from eight values, 25us up to 1.6s
// - per-output polarity high or low, drive open-drain or weak pullup
// - each logic input has a selectable active level applied before use
// - logic inputs feed the watchdog clear or the output stages
// - watchdog expiry asserts every output that selects it
// - watchdog clear from input plus output, input only, or output only
// - first watchdog period picked from eight values, 6.25ms up to 102.4s
// - later watchdog periods use their own separate eight-way setting
// - manual reset low drives every output that selects it active
// - after manual reset rises, outputs deassert only after their full delay
// - user memory writes blocked while write-disable on and chosen output active
// - configuration lock rejects writes to configuration registers
// - each detector flags undervoltage against its code, coarse or fine step
// - detectors two to eight offer a high-impedance third range
// - host reaches user memory and configuration over the parallel slave bus (hsel, haddr, htrans)
// - threshold codes at registers 00h to 07h, range bits at 08h
package sss_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int N_DET         = 8;
    localparam int N_GPI         = 4;
    localparam int N_PO          = 10;
    localparam int UMEM_WORDS    = 16;

    // deassert delays in ns, watchdog periods in us, index 0 first
    localparam longint PO_TMO_NS [8] = '{25000, 1562500, 6250000,
        25000000, 50000000, 200000000, 400000000, 1600000000};
    localparam longint WD_TMO_US [8] = '{6250, 25000, 100000, 400000,
        1600000, 6400000, 25600000, 102400000};

    function automatic logic [7:0][31:0] sss_po_cyc();
        logic [7:0][31:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = 32'((PO_TMO_NS[i] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
        end
        return r;
    endfunction : sss_po_cyc

    function automatic logic [7:0][31:0] sss_wd_cyc();
        logic [7:0][31:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = 32'((WD_TMO_US[i] * 1000 + CLK_PERIOD_NS - 1)
                       / CLK_PERIOD_NS);
        end
        return r;
    endfunction : sss_wd_cyc

    localparam logic [7:0][31:0] SSS_PO_TMO_CYC = sss_po_cyc();
    localparam logic [7:0][31:0] SSS_WD_TMO_CYC = sss_wd_cyc();

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_THR0    = 8'h00;
    localparam logic [7:0] IDX_RANGE   = 8'h08;
    localparam logic [7:0] IDX_PO0     = 8'h10;
    localparam logic [7:0] IDX_GPI     = 8'h20;
    localparam logic [7:0] IDX_WD      = 8'h21;
    localparam logic [7:0] IDX_LOCK    = 8'h22;
    localparam logic [7:0] IDX_STAT    = 8'h23;
    localparam logic [7:0] IDX_IRQ_ST  = 8'h24;
    localparam logic [7:0] IDX_IRQ_MSK = 8'h25;
    localparam logic [7:0] IDX_UMEM0   = 8'h40;

    // range register: fine bits low byte, high-z bits high byte
    localparam int          RNG_HIZ_LSB = 8;
    localparam logic [15:0] RNG_MASK    = 16'hfeff;

    localparam int PO_F_DET_LSB = 0;
    localparam int PO_F_GPI_LSB = 8;
    localparam int PO_F_WD      = 12;
    localparam int PO_F_MR      = 13;
    localparam int PO_F_MARG    = 14;
    localparam int PO_F_TMO_LSB = 15;
    localparam int PO_F_HIGH    = 18;
    localparam int PO_F_OD      = 19;
    localparam int PO_CFG_W     = 20;

    localparam int WD_F_EN       = 0;
    localparam int WD_F_INIT_LSB = 1;
    localparam int WD_F_NORM_LSB = 4;
    localparam int WD_F_MODE_LSB = 7;
    localparam int WD_F_GSEL_LSB = 9;
    localparam int WD_F_PSEL_LSB = 11;
    localparam int WD_CFG_W      = 15;

    localparam int LK_F_CFG      = 0;
    localparam int LK_F_WDIS     = 1;
    localparam int LK_F_WSEL_LSB = 2;
    localparam int LK_W          = 6;

    localparam int EV_WD  = 0;
    localparam int EV_REJ = 1;
    localparam int EV_PO  = 2;
    localparam int N_EV   = 3;

    typedef enum logic [1:0] {
        WDC_BOTH = 2'h0,
        WDC_GPI  = 2'h1,
        WDC_PO   = 2'h2
    } sss_wdclr_e;

    typedef enum logic [1:0] {
        BP_IDLE = 2'h0,
        BP_WR   = 2'h1,
        BP_RD1  = 2'h3,
        BP_RD2  = 2'h2
    } sss_bp_e;
endpackage : sss_pkg

// ===== hdl/sss_wd_if.sv
`timescale 1ns/1ps
interface sss_wd_if;
    logic       en;
    logic [2:0] init_sel;
    logic [2:0] norm_sel;
    logic       clr;
    logic       expire;
    modport ctrl (output en, init_sel, norm_sel, clr, input expire);
    modport wdog (input en, init_sel, norm_sel, clr, output expire);
endinterface : sss_wd_if

// ===== hdl/sss_umem.sv
`timescale 1ns/1ps
module sss_umem #(
    parameter int W  = 32,
    parameter int D  = 16,
    parameter int AW = 4
) (
    input  logic          clk_sys,  // system clock
    input  logic          sys_rst,  // sync reset, high
    input  logic          clk_en,   // freezes state when low
    input  logic          we,       // write strobe
    input  logic [AW-1:0] waddr,    // write word index
    input  logic [W-1:0]  wdata,    // write data
    input  logic          re,       // read strobe
    input  logic [AW-1:0] raddr,    // read word index
    output logic [W-1:0]  rdata     // registered read data
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [W-1:0]        rd;
    } sss_mem_s;

    sss_mem_s mem_reg;
    sss_mem_s mem_next;

    always_comb begin
        mem_next = mem_reg;
        if (we) begin
            mem_next.mem[waddr] = wdata;
        end
        if (re) begin
            mem_next.rd = mem_reg.mem[raddr];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mem_reg <= '0;
        end else if (clk_en) begin
            mem_reg <= mem_next;
        end
    end

    assign rdata = mem_reg.rd;
endmodule : sss_umem

// ===== hdl/sss_wdog.sv
`timescale 1ns/1ps
module sss_wdog import sss_pkg::*; #(
    parameter logic [7:0][31:0] WD_CYC = SSS_WD_TMO_CYC
) (
    input  logic   clk_sys,  // system clock
    input  logic   sys_rst,  // sync reset, high
    input  logic   clk_en,   // freezes state when low
    sss_wd_if.wdog wd        // control and expiry
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        first;
        logic        exp;
    } sss_wd_s;

    sss_wd_s     wd_reg;
    sss_wd_s     wd_next;
    logic [31:0] lim;

    always_comb begin
        wd_next     = wd_reg;
        wd_next.exp = 1'b0;
        lim = wd_reg.first ? WD_CYC[wd.init_sel]
                           : WD_CYC[wd.norm_sel];
        if (!wd.en) begin
            wd_next.cnt   = '0;
            wd_next.first = 1'b1;
        end else if (wd.clr) begin
            wd_next.cnt   = '0;
            wd_next.first = 1'b0;
        end else if (wd_reg.cnt >= lim - 32'h1) begin
            wd_next.cnt   = '0;
            wd_next.first = 1'b0;
            wd_next.exp   = 1'b1;
        end else begin
            wd_next.cnt = wd_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wd_reg <= '{cnt: '0, first: 1'b1, exp: 1'b0};
        end else if (clk_en) begin
            wd_reg <= wd_next;
        end
    end

    assign wd.expire = wd_reg.exp;
endmodule : sss_wdog

// ===== hdl/sss_core.sv
`timescale 1ns/1ps
module sss_core import sss_pkg::*; #(
    parameter logic [7:0][31:0] PO_TMO_CYC = SSS_PO_TMO_CYC,
    parameter logic [7:0][31:0] WD_TMO_CYC = SSS_WD_TMO_CYC
) (
    input  logic                        clk_sys,    // system clock
    input  logic                        sys_rst,    // sync reset, high
    input  logic                        clk_en,     // freezes all state
    input  logic                        hsel,       // slave select
    input  logic [31:0]                 haddr,      // byte address
    input  logic [1:0]                  htrans,     // transfer type
    input  logic                        hwrite,     // write not read
    input  logic [2:0]                  hsize,      // word only
    input  logic                        hready,     // bus ready
    input  logic [31:0]                 hwdata,     // write data
    output logic                        hreadyout,  // slave ready
    output logic                        hresp,      // always okay
    output logic [31:0]                 hrdata,     // read data
    input  logic [N_DET-1:0][7:0]       det_code,   // measured level codes
    output logic [N_DET-1:0][1:0]       det_range,  // {high-z, fine} to analog
    output logic [N_DET-1:0]            det_uv,     // undervoltage flags
    input  logic [N_GPI-1:0]            general_logic_input, // raw pins
    input  logic                        manual_reset_input_n, // low forces
    input  logic                        margin_dis, // margin control
    output logic [N_PO-1:0]             programmable_output_o,  // level
    output logic [N_PO-1:0]             programmable_output_oe, // drive
    output logic [N_PO-1:0]             programmable_output_pu, // pullup on
    output logic                        irq         // level interrupt
);
    typedef struct packed {
        sss_bp_e                    bp;
        logic [7:0]                 idx;
        logic [31:0]                rdata;
        logic [N_DET-1:0][7:0]      thr;
        logic [15:0]                rng;
        logic [N_PO-1:0][PO_CFG_W-1:0] pocfg;
        logic [N_GPI-1:0]           gpol;
        logic [WD_CFG_W-1:0]        wdcfg;
        logic [LK_W-1:0]            lock;
        logic [N_EV-1:0]            ist;
        logic [N_EV-1:0]            imsk;
        logic [N_DET-1:0]           uv;
        logic [N_GPI-1:0]           gprev;
        logic [N_PO-1:0]            pprev;
        logic [N_PO-1:0]            act;
        logic [N_PO-1:0][31:0]      cnt;
    } sss_core_s;

    sss_core_s     st_reg;
    sss_core_s     st_next;
    sss_wd_if      wdi ();

    logic [N_GPI-1:0] gact;
    logic             mr_act;
    logic             acc;
    logic             mem_we;
    logic             mem_re;
    logic [31:0]      mem_rdata;
    logic [N_EV-1:0]  ev;
    logic             gsel_act;
    logic             psel_act;
    logic             gsel_rise;
    logic             psel_rise;

    function automatic logic in_rng(input logic [7:0] idx,
                                    input logic [7:0] base,
                                    input int         n);
        return (idx >= base) && (9'(idx) < 9'(base) + 9'(n));
    endfunction : in_rng

    function automatic logic po_pick(input logic [N_PO-1:0] v,
                                     input logic [3:0]      s);
        return (int'(s) < N_PO) ? v[s] : 1'b0;
    endfunction : po_pick

    function automatic logic is_cfg(input logic [7:0] idx);
        return in_rng(idx, IDX_THR0, N_DET) || idx == IDX_RANGE ||
               in_rng(idx, IDX_PO0, N_PO) || idx == IDX_GPI ||
               idx == IDX_WD;
    endfunction : is_cfg

    assign gact   = general_logic_input ^ st_reg.gpol;
    assign mr_act = ~manual_reset_input_n;
    assign acc    = hsel & htrans[1] & hready;

    // watchdog clear selection
    assign gsel_act  = gact[st_reg.wdcfg[WD_F_GSEL_LSB +: 2]];
    assign gsel_rise = gsel_act &
                       ~st_reg.gprev[st_reg.wdcfg[WD_F_GSEL_LSB +: 2]];
    assign psel_act  = po_pick(st_reg.act, st_reg.wdcfg[WD_F_PSEL_LSB +: 4]);
    assign psel_rise = psel_act & ~po_pick(st_reg.pprev,
                                           st_reg.wdcfg[WD_F_PSEL_LSB +: 4]);

    assign wdi.en       = st_reg.wdcfg[WD_F_EN];
    assign wdi.init_sel = st_reg.wdcfg[WD_F_INIT_LSB +: 3];
    assign wdi.norm_sel = st_reg.wdcfg[WD_F_NORM_LSB +: 3];

    // combined mode: input edge counts only while chosen output is idle
    always_comb begin
        unique case (sss_wdclr_e'(st_reg.wdcfg[WD_F_MODE_LSB +: 2]))
            WDC_BOTH: wdi.clr = gsel_rise & ~psel_act;
            WDC_GPI:  wdi.clr = gsel_rise;
            WDC_PO:   wdi.clr = psel_rise;
            default:  wdi.clr = 1'b0;
        endcase
    end

    sss_wdog #(
        .WD_CYC (WD_TMO_CYC)
    ) u_wdog (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .wd      (wdi.wdog)
    );

    sss_umem #(
        .W  (32),
        .D  (UMEM_WORDS),
        .AW (4)
    ) u_umem (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .we      (mem_we),
        .waddr   (st_reg.idx[3:0]),
        .wdata   (hwdata),
        .re      (mem_re),
        .raddr   (haddr[5:2]),
        .rdata   (mem_rdata)
    );

    assign mem_re = acc & ~hwrite &
                    in_rng(haddr[9:2], IDX_UMEM0, UMEM_WORDS);

    always_comb begin
        logic [31:0]      lim;
        logic             cond;
        logic [3:0]       pi;
        logic [N_PO-1:0]  cfg_src;
        lim     = '0;
        cond    = 1'b0;
        pi      = '0;
        cfg_src = '0;
        st_next = st_reg;
        mem_we  = 1'b0;
        ev      = '0;

        // undervoltage compare, fine and high-z bits only change the scale
        for (int d = 0; d < N_DET; d++) begin
            st_next.uv[d] = det_code[d] < st_reg.thr[d];
        end

        // bus data phase
        unique case (st_reg.bp)
            BP_IDLE, BP_RD2: begin
            end
            BP_WR: begin
                if (is_cfg(st_reg.idx) && st_reg.lock[LK_F_CFG]) begin
                    ev[EV_REJ] = 1'b1;
                end else if (in_rng(st_reg.idx, IDX_THR0, N_DET)) begin
                    st_next.thr[st_reg.idx[2:0]] = hwdata[7:0];
                end else if (st_reg.idx == IDX_RANGE) begin
                    st_next.rng = hwdata[15:0] & RNG_MASK;
                end else if (in_rng(st_reg.idx, IDX_PO0, N_PO)) begin
                    pi = 4'(st_reg.idx - IDX_PO0);
                    st_next.pocfg[pi] = hwdata[PO_CFG_W-1:0];
                end else if (st_reg.idx == IDX_GPI) begin
                    st_next.gpol = hwdata[N_GPI-1:0];
                end else if (st_reg.idx == IDX_WD) begin
                    st_next.wdcfg = hwdata[WD_CFG_W-1:0];
                end else if (st_reg.idx == IDX_LOCK) begin
                    // lock is frozen until reset once its config bit is set; clearing that bit refuses
                    if (st_reg.lock[LK_F_CFG]) begin
                        ev[EV_REJ] = ~hwdata[LK_F_CFG];
                    end else begin
                        st_next.lock = hwdata[LK_W-1:0];
                    end
                end else if (st_reg.idx == IDX_IRQ_ST) begin
                    st_next.ist = st_reg.ist & ~hwdata[N_EV-1:0];
                end else if (st_reg.idx == IDX_IRQ_MSK) begin
                    st_next.imsk = hwdata[N_EV-1:0];
                end else if (in_rng(st_reg.idx, IDX_UMEM0,
                                    UMEM_WORDS)) begin
                    if (st_reg.lock[LK_F_WDIS] &&
                        po_pick(st_reg.act, st_reg.lock[LK_F_WSEL_LSB +: 4]))
                    begin
                        ev[EV_REJ] = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                    end
                end
            end
            BP_RD1: begin
                st_next.bp    = BP_RD2;
                st_next.rdata = '0;
                if (in_rng(st_reg.idx, IDX_THR0, N_DET)) begin
                    st_next.rdata[7:0] = st_reg.thr[st_reg.idx[2:0]];
                end else if (st_reg.idx == IDX_RANGE) begin
                    st_next.rdata[15:0] = st_reg.rng;
                end else if (in_rng(st_reg.idx, IDX_PO0, N_PO)) begin
                    pi = 4'(st_reg.idx - IDX_PO0);
                    st_next.rdata[PO_CFG_W-1:0] = st_reg.pocfg[pi];
                end else if (st_reg.idx == IDX_GPI) begin
                    st_next.rdata[N_GPI-1:0] = st_reg.gpol;
                end else if (st_reg.idx == IDX_WD) begin
                    st_next.rdata[WD_CFG_W-1:0] = st_reg.wdcfg;
                end else if (st_reg.idx == IDX_LOCK) begin
                    st_next.rdata[LK_W-1:0] = st_reg.lock;
                end else if (st_reg.idx == IDX_STAT) begin
                    st_next.rdata[N_DET-1:0] = st_reg.uv;
                    st_next.rdata[N_DET +: N_PO] = st_reg.act;
                end else if (st_reg.idx == IDX_IRQ_ST) begin
                    st_next.rdata[N_EV-1:0] = st_reg.ist;
                end else if (st_reg.idx == IDX_IRQ_MSK) begin
                    st_next.rdata[N_EV-1:0] = st_reg.imsk;
                end else if (in_rng(st_reg.idx, IDX_UMEM0,
                                    UMEM_WORDS)) begin
                    st_next.rdata = mem_rdata;
                end
            end
            default: st_next.bp = BP_IDLE;
        endcase

        // address phase; read data phase holds one wait state
        if (st_reg.bp != BP_RD1) begin
            if (acc) begin
                st_next.bp  = hwrite ? BP_WR : BP_RD1;
                st_next.idx = haddr[9:2];
            end else begin
                st_next.bp = BP_IDLE;
            end
        end

        // output stages
        for (int i = 0; i < N_PO; i++) begin
            cond = |(st_reg.uv &
                     st_reg.pocfg[i][PO_F_DET_LSB +: N_DET]) |
                   |(gact &
                     st_reg.pocfg[i][PO_F_GPI_LSB +: N_GPI]) |
                   (wdi.expire & st_reg.pocfg[i][PO_F_WD]) |
                   (mr_act & st_reg.pocfg[i][PO_F_MR]) |
                   (margin_dis & st_reg.pocfg[i][PO_F_MARG]);
            lim = PO_TMO_CYC[st_reg.pocfg[i][PO_F_TMO_LSB +: 3]];
            if (cond) begin
                st_next.act[i] = 1'b1;
                st_next.cnt[i] = '0;
            end else if (st_reg.act[i]) begin
                if (st_reg.cnt[i] >= lim - 32'h1) begin
                    st_next.act[i] = 1'b0;
                    st_next.cnt[i] = '0;
                end else begin
                    st_next.cnt[i] = st_reg.cnt[i] + 32'h1;
                end
            end
        end
        cfg_src = st_next.act & ~st_reg.act;
        st_next.gprev = gact;
        st_next.pprev = st_reg.act;

        // sticky events, a new event beats a same-cycle clear
        ev[EV_WD] = wdi.expire;
        ev[EV_PO] = |cfg_src;
        st_next.ist = st_next.ist | ev;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg    <= '0;
            st_reg.bp <= BP_IDLE;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // stalling through clk_en low keeps the master parked safely
    assign hreadyout = clk_en & (st_reg.bp != BP_RD1);
    assign hresp     = 1'b0;
    assign hrdata    = st_reg.rdata;
    assign det_uv    = st_reg.uv;
    assign irq       = |(st_reg.ist & st_reg.imsk);

    always_comb begin
        logic lvl;
        lvl = 1'b0;
        for (int d = 0; d < N_DET; d++) begin
            det_range[d] = {st_reg.rng[RNG_HIZ_LSB + d],
                            st_reg.rng[d]};
        end
        for (int i = 0; i < N_PO; i++) begin
            lvl = st_reg.act[i] ^ ~st_reg.pocfg[i][PO_F_HIGH];
            programmable_output_o[i]  = st_reg.pocfg[i][PO_F_OD]
                                        ? 1'b0 : lvl;
            programmable_output_oe[i] = st_reg.pocfg[i][PO_F_OD]
                                        ? ~lvl : 1'b1;
            programmable_output_pu[i] = ~st_reg.pocfg[i][PO_F_OD];
        end
    end
endmodule : sss_core

// ===== test/sss_far_side.sv
`timescale 1ns/1ps
module sss_far_side import sss_pkg::*; (
    input  logic [N_PO-1:0] po_o,   // level from device
    input  logic [N_PO-1:0] po_oe,  // device drives pin
    output logic [N_PO-1:0] line    // pin as the board sees it
);
    // board pull-up: a released open-drain pin reads high
    always_comb begin
        for (int i = 0; i < N_PO; i++) begin
            line[i] = po_oe[i] ? po_o[i] : 1'b1;
        end
    end
endmodule : sss_far_side

// ===== test/sss_core_props.sv
`timescale 1ns/1ps
module sss_core_props import sss_pkg::*; (
    input logic             clk_sys,    // clock
    input logic             sys_rst,    // reset
    input logic             clk_en,     // run
    input logic             hsel,       // select
    input logic [1:0]       htrans,     // type
    input logic             hwrite,     // write
    input logic             hready,     // ready in
    input logic             hreadyout,  // ready out
    input logic             hresp,      // response
    input logic [31:0]      hrdata,     // read data
    input logic [N_DET-1:0] det_uv,     // flags
    input logic [N_PO-1:0]  programmable_output_o,  // level
    input logic [N_PO-1:0]  programmable_output_oe, // drive
    input logic [N_PO-1:0]  programmable_output_pu, // pullup
    input logic             irq         // interrupt
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire take = hsel && htrans[1] && hready && clk_en;
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
    a_read_wait: assert property (take && !hwrite |=>
        !hreadyout ##1 (hreadyout || !clk_en)) else $error("read wait");
    a_write_nowait: assert property (take && hwrite |=>
        hreadyout || !clk_en) else $error("write stalled");
    a_stall_low: assert property (!clk_en |-> !hreadyout)
        else $error("ready while frozen");
    a_rdata_hold: assert property (!$stable(hrdata) |->
        $past(!hreadyout && clk_en)) else $error("read data moved");
    a_reset_idle: assert property (disable iff (1'b0) sys_rst |=>
        programmable_output_o == '1 && programmable_output_oe == '1 &&
        programmable_output_pu == '1 && irq == 1'b0 && det_uv == '0)
        else $error("not idle after reset");
    a_od_low: assert property (
        (programmable_output_o & ~programmable_output_pu) == '0)
        else $error("open drain driving high");
    a_pu_drives: assert property (
        (programmable_output_pu & ~programmable_output_oe) == '0)
        else $error("pullup without drive");
endmodule : sss_core_props

bind sss_core sss_core_props u_props (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .det_uv(det_uv), .irq(irq),
    .programmable_output_o(programmable_output_o),
    .programmable_output_oe(programmable_output_oe),
    .programmable_output_pu(programmable_output_pu));

// ===== test/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    num_errors++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench import sss_pkg::*;;
    localparam logic [7:0][31:0] PO_CYC = {32'd64, 32'd56, 32'd48, 32'd40,
        32'd32, 32'd24, 32'd16, 32'd8};
    localparam logic [7:0][31:0] WD_CYC = {32'd320, 32'd280, 32'd240,
        32'd200, 32'd160, 32'd120, 32'd80, 32'd40};
    localparam int T0 = 8;
    localparam int W0 = 40;
    logic                  clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0;
    logic                  mr_n = 1, marg = 0, ce = 1, hreadyout, hresp, irq;
    logic [1:0]            htrans = 0;
    logic [31:0]           haddr = 0, hwdata = 0, hrdata, rd, rv;
    logic [N_DET-1:0][7:0] code = '0, thr;
    logic [N_DET-1:0][1:0] det_range;
    logic [N_DET-1:0]      det_uv;
    logic [N_GPI-1:0]      gpi = '1;
    logic [N_PO-1:0]       po_o, po_oe, line;
    int num_errors = 0, n_compared = 0, seed = 49, cyc = 0, k;

    sss_core #(.PO_TMO_CYC(PO_CYC), .WD_TMO_CYC(WD_CYC)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .det_code(code),
        .det_range(det_range), .det_uv(det_uv), .irq(irq),
        .general_logic_input(gpi), .manual_reset_input_n(mr_n),
        .margin_dis(marg), .programmable_output_o(po_o),
        .programmable_output_oe(po_oe), .programmable_output_pu());
    sss_far_side far (.po_o(po_o), .po_oe(po_oe), .line(line));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    // master holds each phase until ready is sampled high
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'h0};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic rchk(input logic [7:0] idx, input logic [31:0] ex);
        xfer(1'b0, idx, 32'h0);
        `CHK("register", ex, rd)
    endtask : rchk
    task automatic hold(input int b, input logic v);
        while (line[b] === v && k < 400) begin
            @(posedge clk_sys);
            k++;
        end
    endtask : hold
    function automatic logic [N_DET-1:0] uv_of(
        input logic [N_DET-1:0][7:0] c, input logic [N_DET-1:0][7:0] t);
        for (int i = 0; i < N_DET; i++) uv_of[i] = c[i] < t[i];
    endfunction : uv_of

    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (k = 0; k < N_DET; k++) begin
            thr[k] = 8'($random(seed));
            xfer(1'b1, 8'(k), {24'h0, thr[k]});
        end
        for (k = 0; k < N_DET; k++) rchk(8'(k), {24'h0, thr[k]});
        for (k = 0; k < 20; k++) begin
            code <= (k % 5 == 0) ? thr : {$random(seed), $random(seed)};
            tick(2);
            `CHK("det_uv", uv_of(code, thr), det_uv)
        end
        xfer(1'b1, IDX_RANGE, 32'hffff);
        rchk(IDX_RANGE, {16'h0, RNG_MASK});
        `CHK("det_range", 16'hfffd, det_range)
        ce <= 1'b0;
        tick(2);
        ce <= 1'b1;
        rchk(8'h30, 32'h0);
        xfer(1'b1, IDX_PO0, 32'hc2000);
        mr_n <= 1'b0;
        tick(3);
        `CHK("po_mr", 1'b1, line[0])
        mr_n <= 1'b1;
        tick(4);
        mr_n <= 1'b0;
        tick(2);
        mr_n <= 1'b1;
        tick(T0 - 1);
        `CHK("po_hold", 1'b1, line[0])
        tick(6);
        `CHK("po_release", 1'b0, line[0])
        rv = $random(seed);
        xfer(1'b1, IDX_LOCK, 32'h2);
        xfer(1'b1, IDX_UMEM0, rv);
        mr_n <= 1'b0;
        tick(3);
        xfer(1'b1, IDX_UMEM0, ~rv);
        rchk(IDX_UMEM0, rv);
        mr_n <= 1'b1;
        tick(T0 + 6);
        xfer(1'b1, IDX_UMEM0 + 8'hf, ~rv);
        rchk(IDX_UMEM0 + 8'hf, ~rv);
        xfer(1'b1, IDX_GPI, 32'h1);
        xfer(1'b1, IDX_PO0 + 8'h2, 32'h40100);
        xfer(1'b1, IDX_PO0 + 8'h3, 32'h44000);
        gpi <= 4'($random(seed)) | 4'h1;
        tick(3);
        `CHK("po_src", 2'b00, line[3:2])
        gpi <= 4'h0;
        marg <= 1'b1;
        tick(3);
        `CHK("po_src", 2'b11, line[3:2])
        xfer(1'b1, IDX_PO0 + 8'h1, 32'h1000);
        xfer(1'b1, IDX_WD, 32'h7911);
        k = 0;
        hold(1, 1'b1);
        `CHK("wd_first", 1'b1, k >= W0 - 4 && k <= W0 + 4)
        k = 0;
        hold(1, 1'b0);
        hold(1, 1'b1);
        `CHK("wd_next", 1'b1, k >= 2*W0 - 4 && k <= 2*W0 + 4)
        rchk(IDX_IRQ_ST, 32'h7);
        xfer(1'b1, IDX_IRQ_ST, 32'h7);
        xfer(1'b1, IDX_WD, 32'h81);
        repeat (6) begin
            gpi <= 4'h1;
            tick(2);
            gpi <= 4'h0;
            tick(20);
        end
        rchk(IDX_IRQ_ST, 32'h0);
        xfer(1'b1, IDX_LOCK, 32'h3);
        xfer(1'b1, IDX_THR0, {24'h0, ~thr[0]});
        rchk(IDX_THR0, {24'h0, thr[0]});
        `CHK("irq_masked", 1'b0, irq)
        xfer(1'b1, IDX_IRQ_MSK, 32'h2);
        tick(2);
        `CHK("irq_on", 1'b1, irq)
        xfer(1'b1, IDX_IRQ_ST, 32'h2);
        tick(2);
        `CHK("irq_off", 1'b0, irq)
        results();
    end
endmodule : testbench
